// ==== rxeq_bank.sv ====
/*
 * Paged per-receive-port equalizer and sampling-filter register bank.
 * Assumes a byte register port fed by the serial host front end,
 * one-cycle read and write strobes, and link fault pulses per port.
 */
`timescale 1ns/100ps
module rxeq_bank
    import rxeq_pkg::*;
#(
    parameter int NUM_PORTS = RXEQ_NUM_PORTS,
    parameter int WAIT_BASE_CYC = RXEQ_WAIT_BASE_CYC
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // Register port
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [RXEQ_ADDR_W-1:0] I_REG_ADDR,
    input wire logic [RXEQ_DATA_W-1:0] I_REG_WDATA,
    output logic [RXEQ_DATA_W-1:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    // Receiver lock and equalizer
    input wire logic [NUM_PORTS-1:0] I_LOCK_DET,
    output logic [NUM_PORTS*RXEQ_SET_W-1:0] O_EQ_SETTING,
    output logic [NUM_PORTS-1:0] O_RX_LOCK,
    // Sampling filter
    input wire logic [NUM_PORTS-1:0] I_FILTER_LIMIT,
    input wire logic [NUM_PORTS-1:0] I_FILTER_SETTLED,
    input wire logic [NUM_PORTS-1:0] I_FILTER_MEAS_FAULT,
    input wire logic [NUM_PORTS*RXEQ_DLY_W-1:0] I_FILTER_CDLY,
    input wire logic [NUM_PORTS*RXEQ_DLY_W-1:0] I_FILTER_DDLY,
    // Link fault events and port state reads
    input wire logic [NUM_PORTS-1:0] I_LINK_CODING_FAULT,
    input wire logic [NUM_PORTS-1:0] I_CTRL_CHAN_ORDER_FAULT,
    input wire logic [NUM_PORTS-1:0] I_CTRL_CHAN_CHECK_FAULT,
    input wire logic [NUM_PORTS-1:0] I_PORT_STATE_FIRST_RD,
    input wire logic [NUM_PORTS-1:0] I_PORT_STATE_SECOND_RD,
    // Interrupt
    output logic O_IRQ
);

    // ****************************************
    // Decoding
    // ****************************************
    function automatic logic port_reg(input logic [RXEQ_ADDR_W-1:0] a, input logic [RXEQ_ADDR_W-1:0] t);
        port_reg = (a == t);
    endfunction

    rxeq_page_t page_reg;
    logic [RXEQ_DATA_W-1:0] ctl_reg [NUM_PORTS];
    logic [RXEQ_DATA_W-1:0] ovr_reg [NUM_PORTS];
    logic [RXEQ_DATA_W-1:0] lim_reg [NUM_PORTS];
    logic [RXEQ_DATA_W-1:0] ien_reg [NUM_PORTS];
    logic [NUM_PORTS-1:0] rerun_reg;
    logic [NUM_PORTS-1:0] coding_pend_reg;
    logic [NUM_PORTS-1:0] order_pend_reg;
    logic [NUM_PORTS-1:0] check_pend_reg;
    logic [NUM_PORTS-1:0] irq_src;
    logic [RXEQ_DATA_W-1:0] rdata_next;
    rxeq_flt_a_t flt_a [NUM_PORTS];
    rxeq_flt_b_t flt_b [NUM_PORTS];
    rxeq_state_t eq_state [NUM_PORTS];

    wire wr_page = I_REG_WR && port_reg(I_REG_ADDR, RXEQ_ADDR_PAGE_SEL);
    wire wr_ctl = I_REG_WR && port_reg(I_REG_ADDR, RXEQ_ADDR_EQ_CTL);
    wire wr_ovr = I_REG_WR && port_reg(I_REG_ADDR, RXEQ_ADDR_EQ_OVR);
    wire wr_lim = I_REG_WR && port_reg(I_REG_ADDR, RXEQ_ADDR_EQ_LIM);
    wire wr_ien = I_REG_WR && port_reg(I_REG_ADDR, RXEQ_ADDR_IRQ_EN);
    wire rd_flt_a = I_REG_RD && port_reg(I_REG_ADDR, RXEQ_ADDR_FLT_A);
    wire rd_flt_b = I_REG_RD && port_reg(I_REG_ADDR, RXEQ_ADDR_FLT_B);
    wire [1:0] rport = page_reg.read_port;
    wire rport_ok = (32'(rport) < NUM_PORTS);
    wire rxeq_ctl_t wdata_ctl = rxeq_ctl_t'(I_REG_WDATA);

    // ****************************************
    // Per-port equalizer and filter
    // ****************************************
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            rxeq_cfg_t cfg;
            wire wr_sel = page_reg.write_en[p];
            wire rd_sel = rport_ok && (32'(rport) == p);
            wire [RXEQ_SET_W-1:0] setting;
            rxeq_ctl_t ctl_q;
            rxeq_irq_en_t ien_q;

            assign ctl_q = rxeq_ctl_t'(ctl_reg[p]);
            assign ien_q = rxeq_irq_en_t'(ien_reg[p]);
            assign cfg = '{ctl_q, rxeq_ovr_t'(ovr_reg[p]), rxeq_lim_t'(lim_reg[p])};
            assign O_EQ_SETTING[p*RXEQ_SET_W +: RXEQ_SET_W] = setting;
            assign eq_state[p] = '{2'b00, setting[RXEQ_SET_W-1 -: 3], setting[2:0]};
            assign irq_src[p] = (coding_pend_reg[p] & ien_q.irq_en_link_coding_fault) |
                (order_pend_reg[p] & ien_q.irq_en_ctrl_chan_order_fault) |
                (check_pend_reg[p] & ien_q.irq_en_ctrl_chan_check_fault);

            rxeq_eq_adapt #(
                .WAIT_BASE_CYC(WAIT_BASE_CYC)
            ) u_eq (
                .i_clk(I_CLK),
                .i_rst(I_RST),
                .i_cfg(cfg),
                .i_rerun(rerun_reg[p]),
                .i_lock_det(I_LOCK_DET[p]),
                .o_eq_setting(setting),
                .o_rx_lock(O_RX_LOCK[p])
            );

            rxeq_filter_sts u_flt (
                .i_clk(I_CLK),
                .i_rst(I_RST),
                .i_limit_hit(I_FILTER_LIMIT[p]),
                .i_settled(I_FILTER_SETTLED[p]),
                .i_meas_fault(I_FILTER_MEAS_FAULT[p]),
                .i_cdly(I_FILTER_CDLY[p*RXEQ_DLY_W +: RXEQ_DLY_W]),
                .i_ddly(I_FILTER_DDLY[p*RXEQ_DLY_W +: RXEQ_DLY_W]),
                .i_rd_a(rd_flt_a && rd_sel),
                .i_rd_b(rd_flt_b && rd_sel),
                .o_sts_a(flt_a[p]),
                .o_sts_b(flt_b[p])
            );

            // ****************************************
            // Port registers
            // ****************************************
            always_ff @(posedge I_CLK or posedge I_RST) begin
                if (I_RST) begin
                    ctl_reg[p] <= RXEQ_RST_EQ_CTL;
                    ovr_reg[p] <= RXEQ_RST_EQ_OVR;
                    lim_reg[p] <= RXEQ_RST_EQ_LIM;
                    ien_reg[p] <= RXEQ_RST_IRQ_EN;
                    rerun_reg[p] <= 1'b0;
                end else begin
                    if (wr_ctl && wr_sel) begin
                        ctl_reg[p] <= I_REG_WDATA & RXEQ_WMASK_EQ_CTL;
                    end
                    if (wr_ovr && wr_sel) begin
                        ovr_reg[p] <= I_REG_WDATA;
                    end
                    if (wr_lim && wr_sel) begin
                        lim_reg[p] <= I_REG_WDATA;
                    end
                    if (wr_ien && wr_sel) begin
                        ien_reg[p] <= I_REG_WDATA & RXEQ_WMASK_IRQ_EN;
                    end
                    rerun_reg[p] <= wr_ctl && wr_sel && wdata_ctl.eq_adapt_rerun;
                end
            end

            // Pending faults; a new fault beats a clearing read
            always_ff @(posedge I_CLK or posedge I_RST) begin
                if (I_RST) begin
                    coding_pend_reg[p] <= 1'b0;
                    order_pend_reg[p] <= 1'b0;
                    check_pend_reg[p] <= 1'b0;
                end else begin
                    coding_pend_reg[p] <= I_LINK_CODING_FAULT[p] | (coding_pend_reg[p] & ~I_PORT_STATE_SECOND_RD[p]);
                    order_pend_reg[p] <= I_CTRL_CHAN_ORDER_FAULT[p] | (order_pend_reg[p] & ~I_PORT_STATE_FIRST_RD[p]);
                    check_pend_reg[p] <= I_CTRL_CHAN_CHECK_FAULT[p] | (check_pend_reg[p] & ~I_PORT_STATE_FIRST_RD[p]);
                end
            end
        end
    endgenerate

    // ****************************************
    // Read selection
    // ****************************************
    wire [RXEQ_DATA_W-1:0] rd_ctl = rport_ok ? (ctl_reg[rport] & RXEQ_WMASK_EQ_CTL) : RXEQ_ZERO_BYTE;
    wire [RXEQ_DATA_W-1:0] rd_state = rport_ok ? RXEQ_DATA_W'(eq_state[rport]) : RXEQ_ZERO_BYTE;
    wire [RXEQ_DATA_W-1:0] rd_ovr = rport_ok ? ovr_reg[rport] : RXEQ_ZERO_BYTE;
    wire [RXEQ_DATA_W-1:0] rd_lim = rport_ok ? lim_reg[rport] : RXEQ_ZERO_BYTE;
    wire [RXEQ_DATA_W-1:0] rd_fa = rport_ok ? RXEQ_DATA_W'(flt_a[rport]) : RXEQ_ZERO_BYTE;
    wire [RXEQ_DATA_W-1:0] rd_fb = rport_ok ? RXEQ_DATA_W'(flt_b[rport]) : RXEQ_ZERO_BYTE;
    wire [RXEQ_DATA_W-1:0] rd_ien = rport_ok ? ien_reg[rport] : RXEQ_ZERO_BYTE;

    always_comb begin
        unique case (I_REG_ADDR)
            RXEQ_ADDR_PAGE_SEL: rdata_next = RXEQ_DATA_W'(page_reg);
            RXEQ_ADDR_RSVD_D1: rdata_next = RXEQ_RST_RSVD_D1;
            RXEQ_ADDR_EQ_CTL: rdata_next = rd_ctl;
            RXEQ_ADDR_EQ_STATE: rdata_next = rd_state;
            RXEQ_ADDR_EQ_OVR: rdata_next = rd_ovr;
            RXEQ_ADDR_EQ_LIM: rdata_next = rd_lim;
            RXEQ_ADDR_FLT_A: rdata_next = rd_fa;
            RXEQ_ADDR_FLT_B: rdata_next = rd_fb;
            RXEQ_ADDR_IRQ_EN: rdata_next = rd_ien;
            default: rdata_next = RXEQ_ZERO_BYTE;
        endcase
    end

    // ****************************************
    // Page select, read data, interrupt
    // ****************************************
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            page_reg <= rxeq_page_t'(RXEQ_RST_PAGE_SEL);
            O_REG_RDATA <= RXEQ_ZERO_BYTE;
            O_REG_RVALID <= 1'b0;
            O_IRQ <= 1'b0;
        end else begin
            if (wr_page) begin
                page_reg <= rxeq_page_t'(I_REG_WDATA & RXEQ_WMASK_PAGE_SEL);
            end
            if (I_REG_RD) begin
                O_REG_RDATA <= rdata_next;
            end
            O_REG_RVALID <= I_REG_RD;
            O_IRQ <= |irq_src;
        end
    end

endmodule

// ==== rxeq_checker.sv ====
/* Port checker for rxeq_bank.
   Bound to every rxeq_bank; sees only its ports. */
`timescale 1ns/100ps
module rxeq_checker
    import rxeq_pkg::*;
#(
    parameter int NUM_PORTS = RXEQ_NUM_PORTS
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // Register port
    input wire logic I_REG_RD,
    input wire logic [RXEQ_ADDR_W-1:0] I_REG_ADDR,
    input wire logic [RXEQ_DATA_W-1:0] O_REG_RDATA,
    input wire logic O_REG_RVALID,
    // Lock
    input wire logic [NUM_PORTS-1:0] I_LOCK_DET,
    input wire logic [NUM_PORTS-1:0] O_RX_LOCK
);
    // ************
    // Properties
    // ************
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    sequence s_rd(a);
        I_REG_RD && I_REG_ADDR == a;
    endsequence
    a_read_answered: assert property (I_REG_RD |=> O_REG_RVALID) else $error("no answer");
    a_no_stray_valid: assert property (!I_REG_RD |=> !O_REG_RVALID) else $error("stray valid");
    a_rdata_holds: assert property (!O_REG_RVALID |-> $stable(O_REG_RDATA)) else $error("data moved");
    a_unmapped_zero: assert property (s_rd(8'h00) |=> O_REG_RDATA == 8'h00) else $error("unmapped");
    a_fixed_reserved: assert property (s_rd(8'hd1) |=> O_REG_RDATA == 8'h43) else $error("reserved");
    a_state_top_zero: assert property (s_rd(8'hd3) |=> O_REG_RDATA[7:6] == 2'b00) else $error("state");
    a_rerun_reads_zero: assert property (s_rd(8'hd2) |=> !O_REG_RDATA[3]) else $error("rerun bit");
    a_irq_en_upper: assert property (s_rd(8'hd8) |=> O_REG_RDATA[7:3] == 5'h00) else $error("enables");
    a_lock_needs_det: assert property ((O_RX_LOCK & ~($past(I_LOCK_DET) | $past(I_LOCK_DET, 2))) == '0)
        else $error("lock without detect");
endmodule
bind rxeq_bank rxeq_checker #(.NUM_PORTS(NUM_PORTS)) i_chk (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR), .O_REG_RDATA(O_REG_RDATA),
    .O_REG_RVALID(O_REG_RVALID), .I_LOCK_DET(I_LOCK_DET), .O_RX_LOCK(O_RX_LOCK)
);

// ==== rxeq_eq_adapt.sv ====
/*
 * Adaptive equalizer stepping for one receive port.
 * Assumes a lock detector level synchronous to the clock.
 */
`timescale 1ns/100ps
module rxeq_eq_adapt
    import rxeq_pkg::*;
#(
    parameter int WAIT_BASE_CYC = RXEQ_WAIT_BASE_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire rxeq_cfg_t i_cfg,
    input wire logic i_rerun,
    input wire logic i_lock_det,
    // Results
    output logic [RXEQ_SET_W-1:0] o_eq_setting,
    output logic o_rx_lock
);

    rxeq_fsm_t state_reg, state_next;
    logic [RXEQ_AEQ_W-1:0] eq_reg, eq_next;
    logic [RXEQ_WAIT_CNT_W-1:0] cnt_reg, cnt_next;
    logic first_reg, first_next;
    logic [RXEQ_SET_W-1:0] set_next;
    logic lock_next;
    wire [RXEQ_WAIT_CNT_W-1:0] wait_base = RXEQ_WAIT_CNT_W'(WAIT_BASE_CYC);
    wire [RXEQ_WAIT_CNT_W-1:0] wait_limit = wait_base << i_cfg.ctl.eq_step_wait_time;
    wire wait_end = (cnt_reg >= wait_limit - RXEQ_WAIT_CNT_W'(1));
    wire [RXEQ_AEQ_W-1:0] start_val = i_cfg.ctl.eq_floor_enable ? i_cfg.lim.eq_start_floor : '0;

    // ****************************************
    // Stepping
    // ****************************************
    always_comb begin
        state_next = state_reg;
        eq_next = eq_reg;
        cnt_next = cnt_reg + RXEQ_WAIT_CNT_W'(1);
        first_next = first_reg;
        if (i_cfg.ovr.eq_adapt_disable) begin
            state_next = RXEQ_SETTLED;
            cnt_next = '0;
        end else if (i_rerun) begin
            eq_next = start_val;
            state_next = RXEQ_SEARCH;
            cnt_next = '0;
            first_next = 1'b0;
        end else if (i_lock_det && !first_reg) begin
            first_next = 1'b1;
            cnt_next = '0;
            if (i_cfg.ctl.first_lock_restart_zero) begin
                eq_next = start_val;
                state_next = RXEQ_SEARCH;
            end else begin
                state_next = RXEQ_SETTLED;
            end
        end else begin
            unique case (state_reg)
                RXEQ_SEARCH: begin
                    if (wait_end) begin
                        cnt_next = '0;
                        if (i_lock_det) begin
                            state_next = RXEQ_SETTLED;
                        end else if (eq_reg >= i_cfg.lim.eq_ceiling) begin
                            eq_next = start_val;
                        end else begin
                            eq_next = eq_reg + RXEQ_AEQ_W'(1);
                        end
                    end
                end
                RXEQ_SETTLED: begin
                    cnt_next = '0;
                    if (!i_lock_det) begin
                        state_next = RXEQ_SEARCH;
                    end
                end
                default: begin
                    state_next = RXEQ_SEARCH;
                end
            endcase
        end
    end

    // Applied setting and reported lock
    assign set_next = i_cfg.ovr.eq_adapt_disable ?
        {i_cfg.ovr.manual_eq_upper_bits, i_cfg.ovr.manual_eq_lower_bits} :
        {{(RXEQ_SET_W-RXEQ_AEQ_W){1'b0}}, eq_reg};
    assign lock_next = i_cfg.ovr.lock_waits_for_eq ? (i_lock_det && state_reg == RXEQ_SETTLED) : i_lock_det;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= RXEQ_SEARCH;
            eq_reg <= '0;
            cnt_reg <= '0;
            first_reg <= 1'b0;
            o_eq_setting <= '0;
            o_rx_lock <= 1'b0;
        end else begin
            state_reg <= state_next;
            eq_reg <= eq_next;
            cnt_reg <= cnt_next;
            first_reg <= first_next;
            o_eq_setting <= set_next;
            o_rx_lock <= lock_next;
        end
    end

endmodule

// ==== rxeq_far_end.sv ====
/* Far-end link model: lock detector and link fault pulses.
   Faults reach port 0 only; requests come on rising edges. */
`timescale 1ns/100ps
module rxeq_far_end
#(
    parameter int N = 4,
    parameter int LOCK_DLY = 3
) (
    // Clock
    input wire logic i_clk,
    // Bench requests
    input wire logic [N-1:0] i_link_up,
    input wire logic [2:0] i_fault,
    // Toward the bank
    output logic [N-1:0] o_lock_det,
    output logic [N-1:0] o_coding,
    output logic [N-1:0] o_order,
    output logic [N-1:0] o_check
);
    // ************
    // Lock after LOCK_DLY cycles of link
    // ************
    logic [N-1:0] hist[LOCK_DLY];
    always @(posedge i_clk) begin
        hist[0] <= i_link_up;
        for (int k = 1; k < LOCK_DLY; k++) hist[k] <= hist[k-1];
        o_check <= N'(i_fault[0]);
        o_order <= N'(i_fault[1]);
        o_coding <= N'(i_fault[2]);
    end
    always_comb begin
        o_lock_det = i_link_up;
        for (int k = 0; k < LOCK_DLY; k++) o_lock_det &= hist[k];
    end
endmodule

// ==== rxeq_filter_sts.sv ====
/*
 * Sampling-filter status flags for one receive port.
 * Assumes filter inputs synchronous to the clock; read strobes are one cycle.
 */
`timescale 1ns/100ps
module rxeq_filter_sts
    import rxeq_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Filter inputs
    input wire logic i_limit_hit,
    input wire logic i_settled,
    input wire logic i_meas_fault,
    input wire logic [RXEQ_DLY_W-1:0] i_cdly,
    input wire logic [RXEQ_DLY_W-1:0] i_ddly,
    // Read strobes
    input wire logic i_rd_a,
    input wire logic i_rd_b,
    // Status
    output rxeq_flt_a_t o_sts_a,
    output rxeq_flt_b_t o_sts_b
);

    // Sticky set wins over clear on read; settled sticks low until a read reloads it
    wire limit_next = i_limit_hit | (o_sts_a.filter_limit_hit & ~i_rd_a);
    wire settled_next = i_rd_a ? i_settled : (o_sts_a.filter_settled & i_settled);
    wire fault_next = i_meas_fault | (o_sts_b.filter_measure_fault & ~i_rd_b);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sts_a <= '0;
            o_sts_b <= '0;
        end else begin
            o_sts_a <= '{limit_next, settled_next, i_cdly};
            o_sts_b <= '{1'b0, fault_next, i_ddly};
        end
    end

endmodule

// ==== rxeq_pkg.sv ====
/*
 * Constants, register layouts and types for the receive-port equalizer
 * and sampling-filter register bank.
 * Assumes a 100 MHz device clock and byte-wide register access.
 */
package rxeq_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int RXEQ_NUM_PORTS = 4;
    localparam int RXEQ_ADDR_W = 8;
    localparam int RXEQ_DATA_W = 8;
    localparam int RXEQ_SET_W = 6;
    localparam int RXEQ_DLY_W = 6;
    localparam int RXEQ_AEQ_W = 4;
    localparam int RXEQ_WAIT_CNT_W = 22;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] RXEQ_ADDR_PAGE_SEL = 8'h4c;
    localparam logic [7:0] RXEQ_ADDR_RSVD_D1 = 8'hd1;
    localparam logic [7:0] RXEQ_ADDR_EQ_CTL = 8'hd2;
    localparam logic [7:0] RXEQ_ADDR_EQ_STATE = 8'hd3;
    localparam logic [7:0] RXEQ_ADDR_EQ_OVR = 8'hd4;
    localparam logic [7:0] RXEQ_ADDR_EQ_LIM = 8'hd5;
    localparam logic [7:0] RXEQ_ADDR_FLT_A = 8'hd6;
    localparam logic [7:0] RXEQ_ADDR_FLT_B = 8'hd7;
    localparam logic [7:0] RXEQ_ADDR_IRQ_EN = 8'hd8;

    // ****************************************
    // Reset values and write masks
    // ****************************************
    localparam logic [7:0] RXEQ_RST_PAGE_SEL = 8'h01;
    localparam logic [7:0] RXEQ_RST_RSVD_D1 = 8'h43;
    localparam logic [7:0] RXEQ_RST_EQ_CTL = 8'h94;
    localparam logic [7:0] RXEQ_RST_EQ_OVR = 8'h60;
    localparam logic [7:0] RXEQ_RST_EQ_LIM = 8'hf2;
    localparam logic [7:0] RXEQ_RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RXEQ_WMASK_PAGE_SEL = 8'h3f;
    localparam logic [7:0] RXEQ_WMASK_EQ_CTL = 8'hf4;
    localparam logic [7:0] RXEQ_WMASK_IRQ_EN = 8'h07;
    localparam logic [7:0] RXEQ_ZERO_BYTE = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int RXEQ_CLK_PERIOD_NS = 10;
    localparam int RXEQ_WAIT_BASE_NS = 164000;
    localparam int RXEQ_WAIT_BASE_CYC = (RXEQ_WAIT_BASE_NS + RXEQ_CLK_PERIOD_NS - 1) / RXEQ_CLK_PERIOD_NS;

    // ****************************************
    // Register layouts
    // ****************************************
    typedef struct packed {
        logic [2:0] eq_step_wait_time;
        logic first_lock_restart_zero;
        logic eq_adapt_rerun;
        logic eq_floor_enable;
        logic [1:0] rsvd;
    } rxeq_ctl_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic [2:0] eq_state_upper;
        logic [2:0] eq_state_lower;
    } rxeq_state_t;

    typedef struct packed {
        logic [2:0] manual_eq_upper_bits;
        logic lock_waits_for_eq;
        logic [2:0] manual_eq_lower_bits;
        logic eq_adapt_disable;
    } rxeq_ovr_t;

    typedef struct packed {
        logic [3:0] eq_ceiling;
        logic [3:0] eq_start_floor;
    } rxeq_lim_t;

    typedef struct packed {
        logic filter_limit_hit;
        logic filter_settled;
        logic [5:0] filter_clock_delay;
    } rxeq_flt_a_t;

    typedef struct packed {
        logic rsvd;
        logic filter_measure_fault;
        logic [5:0] filter_data_delay;
    } rxeq_flt_b_t;

    typedef struct packed {
        logic [4:0] rsvd;
        logic irq_en_link_coding_fault;
        logic irq_en_ctrl_chan_order_fault;
        logic irq_en_ctrl_chan_check_fault;
    } rxeq_irq_en_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic [1:0] read_port;
        logic [3:0] write_en;
    } rxeq_page_t;

    typedef struct packed {
        rxeq_ctl_t ctl;
        rxeq_ovr_t ovr;
        rxeq_lim_t lim;
    } rxeq_cfg_t;

    typedef enum logic [1:0] {
        RXEQ_SEARCH = 2'b01,
        RXEQ_SETTLED = 2'b10
    } rxeq_fsm_t;

endpackage

// ==== rxeq_tb.sv ====
/* Bench for rxeq_bank with the far-end model.
   Assumes the package; short step wait. */
`timescale 1ns/100ps
module testbench;
    import rxeq_pkg::*;
    // ************
    // Signals and model
    // ************
    localparam int WB = 4;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rvld, irq;
    logic [7:0] addr = 8'h00, wdat = 8'h00, rdat;
    logic [3:0] up = 4'h0, lim = 4'h0, stl = 4'h0, mf = 4'h0, sr1 = 4'h0, sr2 = 4'h0;
    logic [3:0] ldet, cf, of, kf, rxl;
    logic [2:0] flt = 3'h0;
    logic [23:0] cd = 24'h0, dd = 24'h0, eqs;
    logic [15:0] rnd = 16'h785b;
    int err_total = 0, comparisons = 0, cycles = 0, m_pg = 1;
    int m_r[4][4];
    logic [7:0] ta[4] = '{8'hd2, 8'hd4, 8'hd5, 8'hd8};
    logic [7:0] tm[4] = '{8'hf4, 8'hff, 8'hff, 8'h07};
    rxeq_far_end #(.N(4), .LOCK_DLY(3)) i_far (
        .i_clk(clk), .i_link_up(up), .i_fault(flt), .o_lock_det(ldet), .o_coding(cf), .o_order(of), .o_check(kf)
    );
    rxeq_bank #(.NUM_PORTS(4), .WAIT_BASE_CYC(WB)) i_dut (
        .I_CLK(clk), .I_RST(rst), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdat),
        .O_REG_RDATA(rdat), .O_REG_RVALID(rvld), .I_LOCK_DET(ldet), .O_EQ_SETTING(eqs), .O_RX_LOCK(rxl),
        .I_FILTER_LIMIT(lim), .I_FILTER_SETTLED(stl), .I_FILTER_MEAS_FAULT(mf), .I_FILTER_CDLY(cd),
        .I_FILTER_DDLY(dd), .I_LINK_CODING_FAULT(cf), .I_CTRL_CHAN_ORDER_FAULT(of),
        .I_CTRL_CHAN_CHECK_FAULT(kf), .I_PORT_STATE_FIRST_RD(sr1), .I_PORT_STATE_SECOND_RD(sr2), .O_IRQ(irq)
    );
    // ************
    // Tasks
    // ************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        exp_reg = (a == 8'h4c) ? 8'(m_pg) : 8'h00;
        for (int i = 0; i < 4; i++) if (a == ta[i]) exp_reg = 8'(m_r[(m_pg >> 4) & 3][i]);
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        wr <= 1'b0;
        if (a == 8'h4c) m_pg = int'(d & 8'h3f);
        for (int p = 0; p < 4; p++)
            for (int i = 0; i < 4; i++) if (m_pg[p] && a == ta[i]) m_r[p][i] = int'(d & tm[i]);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk8({7'h00, rvld}, 8'h01);
        cyc(1);
        v = rdat;
    endtask
    task automatic rc(input logic [7:0] a);
        logic [7:0] v;
        rd_reg(a, v);
        chk8(v, exp_reg(a));
    endtask
    task automatic step_gap(output int n);
        logic [5:0] s;
        n = 0;
        s = eqs[5:0];
        while (eqs[5:0] === s && n < 400) begin
            cyc(1);
            n++;
        end
    endtask
    // ************
    // Sequence
    // ************
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        logic [7:0] v;
        logic [5:0] s0;
        int n;
        for (int p = 0; p < 4; p++) m_r[p] = '{32'h94, 32'h60, 32'hf2, 32'h00};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rc(8'h4c);
        foreach (ta[i]) rc(ta[i]);
        rc(8'hd3);
        rc(8'hd6);
        rc(8'hd7);
        wr_reg(8'hd1, 8'h00);
        wr_reg(8'h00, 8'hff);
        rd_reg(8'hd1, v);
        chk8(v, 8'h43);
        rc(8'h00);
        repeat (24) begin
            rnd = lfsr(rnd);
            wr_reg(8'h4c, rnd[7:0]);
            rnd = lfsr(rnd);
            wr_reg(ta[rnd[9:8]], rnd[7:0]);
            rc(ta[rnd[11:10]]);
        end
        wr_reg(8'h4c, 8'h01);
        wr_reg(8'hd8, 8'h00);
        wr_reg(8'hd5, 8'h42);
        wr_reg(8'hd4, 8'ha5);
        wr_reg(8'hd3, 8'hff);
        cyc(3);
        chk8({2'b00, eqs[5:0]}, 8'h2a);
        rd_reg(8'hd3, v);
        chk8(v, 8'h2a);
        wr_reg(8'hd4, 8'h00);
        for (int c = 0; c < 3; c++) begin
            wr_reg(8'hd2, 8'(c << 5) | 8'h04);
            step_gap(n);
            repeat (4) begin
                s0 = eqs[5:0];
                step_gap(n);
                chk8(8'(n), 8'(WB << c));
                chk8({2'b00, eqs[5:0]}, (s0 >= 6'h04) ? 8'h02 : {2'b00, s0 + 6'h01});
            end
        end
        do step_gap(n);
        while (eqs[5:0] == 6'h02);
        wr_reg(8'hd2, 8'h4c);
        cyc(4);
        chk8({2'b00, eqs[5:0]}, 8'h02);
        rc(8'hd2);
        wr_reg(8'hd2, 8'h54);
        wr_reg(8'hd4, 8'h10);
        @(posedge clk);
        up <= 4'h1;
        cyc(12);
        chk8({rxl[0], 1'b0, eqs[5:0]}, 8'h02);
        n = 0;
        while (rxl[0] !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk8({7'h00, rxl[0]}, 8'h01);
        s0 = eqs[5:0];
        cyc(40);
        chk8({2'b00, eqs[5:0]}, {2'b00, s0});
        @(posedge clk);
        up <= 4'h0;
        cyc(3);
        chk8({7'h00, rxl[0]}, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr_reg(8'hd8, 8'h00);
            @(posedge clk);
            flt <= 3'(1 << k);
            @(posedge clk);
            flt <= 3'h0;
            cyc(4);
            chk8({7'h00, irq}, 8'h00);
            wr_reg(8'hd8, 8'(1 << k));
            cyc(3);
            chk8({7'h00, irq}, 8'h01);
            @(posedge clk);
            sr1 <= (k < 2) ? 4'h1 : 4'h0;
            sr2 <= (k == 2) ? 4'h1 : 4'h0;
            @(posedge clk);
            sr1 <= 4'h0;
            sr2 <= 4'h0;
            cyc(3);
            chk8({7'h00, irq}, 8'h00);
        end
        rnd = lfsr(rnd);
        @(posedge clk);
        cd <= {4{rnd[5:0]}};
        dd <= {4{rnd[11:6]}};
        stl <= 4'hf;
        cyc(3);
        rd_reg(8'hd6, v);
        chk8(v, {2'b00, rnd[5:0]});
        rd_reg(8'hd6, v);
        chk8(v, {2'b01, rnd[5:0]});
        @(posedge clk);
        lim <= 4'h1;
        mf <= 4'h1;
        stl <= 4'he;
        @(posedge clk);
        lim <= 4'h0;
        mf <= 4'h0;
        stl <= 4'hf;
        cyc(3);
        rd_reg(8'hd6, v);
        chk8(v, {2'b10, rnd[5:0]});
        rd_reg(8'hd7, v);
        chk8(v, {2'b01, rnd[11:6]});
        rd_reg(8'hd6, v);
        chk8(v, {2'b01, rnd[5:0]});
        rd_reg(8'hd7, v);
        chk8(v, {2'b00, rnd[11:6]});
        print_verdict();
    end
endmodule
